// ==== pcisb_pkg.sv ====
// Shared constants and carrier types for the PCI sideband block.
// Assumes every bus signal is synchronous to the PCI clock CLK.
package pcisb_pkg;

    // ***********************************
    // Command codes
    // ***********************************
    localparam logic [3:0] CMD_CFG_READ = 4'ha;
    localparam logic [3:0] CMD_CFG_WRITE = 4'hb;

    // ***********************************
    // Field positions
    // ***********************************
    localparam int CMD_WRITE_BIT = 0;

    // ***********************************
    // Reset values
    // ***********************************
    localparam logic PIN_IDLE = 1'h1;
    localparam logic OE_OFF_N = 1'h1;
    localparam logic FLAG_CLEAR = 1'h0;

    // ***********************************
    // Timing counts in clocks
    // ***********************************
    localparam int PERR_LAG = 2;
    localparam int SERR_LAG = 2;

    // Snapshot of the shared bus lines in one clock
    typedef struct packed {
        logic [31:0] ad;
        logic [3:0] cbe_n;
        logic par;
        logic frame_n;
        logic irdy_n;
        logic trdy_n;
    } pcisb_bus_s;

    // Open-drain or tri-state pin, enable low while driving
    typedef struct packed {
        logic out;
        logic oe_n;
    } pcisb_pin_s;

    // Even parity bit that makes the ones count even
    function automatic logic pcisb_even_par(
        input logic [31:0] ad,
        input logic [3:0] cbe_n
    );
        pcisb_even_par = ^{ad, cbe_n};
    endfunction

endpackage

// ==== pcisb_parity.sv ====
// Parity checker for one bus phase.
// Assumes PAR arrives one clock after the address/data it covers.
`timescale 1ns/1ps
module pcisb_parity
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic capture,
    input wire logic [31:0] ad,
    input wire logic [3:0] cbe_n,
    input wire logic par,
    output logic mismatch
);
    import pcisb_pkg::*;

    logic expect_par;
    logic armed;

    // ***********************************
    // Capture phase, compare next clock
    // ***********************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            expect_par <= FLAG_CLEAR;
            armed <= FLAG_CLEAR;
        end
        else if (ce)
        begin
            armed <= capture;
            if (capture)
            begin
                expect_par <= pcisb_even_par(ad, cbe_n);
            end
        end
    end

    assign mismatch = armed && (expect_par != par);

endmodule

// ==== pcisb_sideband.sv ====
// PCI sideband control: decode claim, parity reporting, interrupts,
// request and grant, and clock rate indication.
// Assumes bus lines are synchronous to CLK; M66EN may be asynchronous.
`timescale 1ns/1ps
module pcisb_sideband
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire pcisb_pkg::pcisb_bus_s BUS,
    input wire logic IDSEL,
    input wire logic GNT_N,
    input wire logic M66EN,
    input wire logic PERR_N_IN,
    input wire logic MEM_HIT,
    input wire logic MST_NEED,
    input wire logic MST_ACTIVE,
    input wire logic MST_WRITE,
    input wire logic L2_IRQ_PENDING,
    input wire logic EXP_IRQ_PENDING,
    output pcisb_pkg::pcisb_pin_s DEVSEL,
    output pcisb_pkg::pcisb_pin_s PERR,
    output pcisb_pkg::pcisb_pin_s SERR,
    output pcisb_pkg::pcisb_pin_s INTA,
    output pcisb_pkg::pcisb_pin_s INTB,
    output logic REQ_N,
    output logic MST_GO,
    output logic CFG_SELECT,
    output logic PERR_DESC,
    output logic M66_MODE
);
    import pcisb_pkg::*;

    typedef enum logic [3:0] {
        TGT_IDLE = 4'h1,
        TGT_CLAIM = 4'h2,
        TGT_TURN = 4'h4,
        TGT_SPARE = 4'h8
    } pcisb_tgt_e;

    pcisb_tgt_e tgt_state;
    pcisb_tgt_e next_tgt_state;
    logic frame_q;
    logic addr_phase;
    logic cfg_cmd;
    logic cfg_hit;
    logic claim;
    logic tgt_write;
    logic data_phase;
    logic rx_phase;
    logic tx_phase;
    logic [PERR_LAG-1:0] tx_pipe;
    logic addr_err;
    logic data_err;
    logic perr_turn;
    logic m66_meta;
    logic bus_idle;

    default clocking pcisb_cb @(posedge CLK);
    endclocking
    default disable iff (RESET || !CE);

    // ***********************************
    // Phase decode
    // ***********************************
    assign addr_phase = frame_q && !BUS.frame_n;
    assign cfg_cmd = (BUS.cbe_n == CMD_CFG_READ) ||
                     (BUS.cbe_n == CMD_CFG_WRITE);
    assign cfg_hit = IDSEL && cfg_cmd;
    assign claim = addr_phase && (MEM_HIT || cfg_hit);
    assign data_phase = !BUS.irdy_n && !BUS.trdy_n;
    assign rx_phase = data_phase && (((tgt_state == TGT_CLAIM) && tgt_write)
                      || (MST_ACTIVE && !MST_WRITE));
    assign tx_phase = data_phase && MST_ACTIVE && MST_WRITE;
    assign bus_idle = BUS.frame_n && BUS.irdy_n;

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            frame_q <= PIN_IDLE;
            tgt_write <= FLAG_CLEAR;
        end
        else if (CE)
        begin
            frame_q <= BUS.frame_n;
            if (addr_phase)
            begin
                tgt_write <= BUS.cbe_n[CMD_WRITE_BIT];
            end
        end
    end

    // ***********************************
    // Parity checkers
    // ***********************************
    // Even parity one clock late
    pcisb_parity u_addr_par
    (
        .clk(CLK), .reset(RESET), .ce(CE), .capture(addr_phase),
        .ad(BUS.ad), .cbe_n(BUS.cbe_n), .par(BUS.par),
        .mismatch(addr_err)
    );

    pcisb_parity u_data_par
    (
        .clk(CLK), .reset(RESET), .ce(CE), .capture(rx_phase),
        .ad(BUS.ad), .cbe_n(BUS.cbe_n), .par(BUS.par),
        .mismatch(data_err)
    );

    // ***********************************
    // Target claim
    // ***********************************
    always_comb
    begin
        next_tgt_state = tgt_state;
        unique case (tgt_state)
            TGT_IDLE:
                if (claim)
                begin
                    next_tgt_state = TGT_CLAIM;
                end
            TGT_CLAIM:
                if (bus_idle)
                begin
                    next_tgt_state = TGT_TURN;
                end
            TGT_TURN:
                next_tgt_state = TGT_IDLE;
            default:
                next_tgt_state = TGT_IDLE;
        endcase
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            tgt_state <= TGT_IDLE;
            DEVSEL <= '{out: PIN_IDLE, oe_n: OE_OFF_N};
            CFG_SELECT <= FLAG_CLEAR;
        end
        else if (CE)
        begin
            tgt_state <= next_tgt_state;
            DEVSEL.out <= !(next_tgt_state == TGT_CLAIM);
            DEVSEL.oe_n <= (next_tgt_state == TGT_IDLE);
            if (claim)
            begin
                CFG_SELECT <= cfg_hit && !MEM_HIT;
            end
            else if (next_tgt_state == TGT_IDLE)
            begin
                CFG_SELECT <= FLAG_CLEAR;
            end
        end
    end
    a_devsel_after_decode: assert property (
        $fell(DEVSEL.out) |-> $past(claim))
        else $error("DEVSEL asserted without decode");
    a_cfg_needs_idsel: assert property (
        $rose(CFG_SELECT) |-> $past(IDSEL))
        else $error("Config select without IDSEL");

    // ***********************************
    // Parity error reporting
    // ***********************************
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            PERR <= '{out: PIN_IDLE, oe_n: OE_OFF_N};
            perr_turn <= FLAG_CLEAR;
            SERR <= '{out: FLAG_CLEAR, oe_n: OE_OFF_N};
            tx_pipe <= '0;
            PERR_DESC <= FLAG_CLEAR;
        end
        else if (CE)
        begin
            perr_turn <= data_err;
            PERR.out <= !data_err;
            PERR.oe_n <= !(data_err || perr_turn);
            SERR.oe_n <= !addr_err;
            SERR.out <= FLAG_CLEAR;
            tx_pipe <= {tx_pipe[PERR_LAG-2:0], tx_phase};
            PERR_DESC <= (tx_pipe[PERR_LAG-1] && !PERR_N_IN) ||
                         (data_err && MST_ACTIVE && !MST_WRITE);
        end
    end
    a_serr_addr_only: assert property (
        $fell(SERR.oe_n) |-> $past(addr_phase, SERR_LAG))
        else $error("SERR without address phase");
    a_serr_open_drain: assert property (
        disable iff (RESET) !SERR.oe_n |-> !SERR.out)
        else $error("SERR driven high");
    a_perr_timing: assert property (
        $fell(PERR.out) |-> $past(rx_phase, PERR_LAG))
        else $error("PERR not two clocks after data");
    a_perr_turnaround: assert property (
        (!PERR.out && !PERR.oe_n) ##1 PERR.out |-> !PERR.oe_n)
        else $error("PERR released without driving high");
    a_desc_write_perr: assert property (
        (tx_pipe[PERR_LAG-1] && !PERR_N_IN) |=> PERR_DESC)
        else $error("No descriptor after PERR on write");
    a_desc_read_err: assert property (
        (data_err && MST_ACTIVE && !MST_WRITE) |=> PERR_DESC && !PERR.out)
        else $error("No descriptor after read parity error");

    // ***********************************
    // Interrupts, arbitration, rate
    // ***********************************
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            INTA <= '{out: FLAG_CLEAR, oe_n: OE_OFF_N};
            INTB <= '{out: FLAG_CLEAR, oe_n: OE_OFF_N};
        end
        else if (CE)
        begin
            INTA.oe_n <= !L2_IRQ_PENDING;
            INTB.oe_n <= !EXP_IRQ_PENDING;
        end
    end
    a_inta_level: assert property (
        L2_IRQ_PENDING [*2] |-> !INTA.oe_n && !INTA.out)
        else $error("INTA not held while pending");

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            REQ_N <= PIN_IDLE;
            MST_GO <= FLAG_CLEAR;
        end
        else if (CE)
        begin
            REQ_N <= !MST_NEED;
            MST_GO <= MST_NEED && !REQ_N && !GNT_N && bus_idle &&
                      !MST_ACTIVE && !MST_GO;
        end
    end
    a_go_needs_grant: assert property (
        MST_GO |-> $past(!GNT_N) && !REQ_N)
        else $error("Master start without grant");

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            m66_meta <= FLAG_CLEAR;
            M66_MODE <= FLAG_CLEAR;
        end
        else if (CE)
        begin
            m66_meta <= M66EN;
            M66_MODE <= m66_meta;
        end
    end
    a_m66_follows: assert property (
        M66EN [*3] |-> M66_MODE)
        else $error("M66 mode not following input");

endmodule

// ==== pcisb_host_model.sv ====
// Far side model: host parity source, arbiter and shared error line.
// Assumes the bench drives the address/data and command lines.
`timescale 1ns/1ps
module pcisb_host_model
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [31:0] AD,
    input wire logic [3:0] CBE_N,
    input wire logic BAD_PAR,
    input wire logic HOLD_GNT,
    input wire logic FLAG_PERR,
    input wire logic REQ_N,
    input wire pcisb_pkg::pcisb_pin_s PERR,
    output logic PAR,
    output logic GNT_N,
    output logic PERR_LINE_N
);
    import pcisb_pkg::*;
    always_ff @(posedge CLK)
        PAR <= ^{AD, CBE_N} ^ BAD_PAR;
    always_ff @(posedge CLK or posedge RESET)
        if (RESET)
            GNT_N <= 1'h1;
        else
            GNT_N <= REQ_N | HOLD_GNT;
    assign PERR_LINE_N = FLAG_PERR ? 1'h0 : (PERR.oe_n ? 1'h1 : PERR.out);
endmodule

// ==== pcisb_sideband_test.sv ====
// Self-checking bench for the PCI sideband block.
// Assumes the host model supplies parity, grant and the error line.
`timescale 1ns/1ps
module pcisb_sideband_test;
    import pcisb_pkg::*;
    logic clk = 1'h0, rst = 1'h1, idsel = 1'h0, m66 = 1'h0;
    logic [31:0] ad = 32'h0;
    logic [3:0] cbe = 4'hf;
    logic fr = 1'h1, ir = 1'h1, bad = 1'h0, hold = 1'h1, flag = 1'h0;
    logic hit = 1'h0, need = 1'h0, act = 1'h0, wr = 1'h0;
    logic l2 = 1'h0, ex = 1'h0;
    logic par, gnt_n, perr_n, req_n, go, cfg, desc, m66_mode;
    pcisb_pin_s devsel, perr, serr, inta, intb;
    pcisb_bus_s bus;
    int n_errors = 0, checks_done = 0, cyc = 0;
    int n_serr = 0, n_perr = 0, n_desc = 0, n_go = 0, b0, b1, b2;
    assign bus = '{ad, cbe, par, fr, ir, ir};
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    pcisb_sideband i_dut (.CLK(clk), .RESET(rst), .CE(1'h1), .BUS(bus),
        .IDSEL(idsel), .GNT_N(gnt_n), .M66EN(m66), .PERR_N_IN(perr_n),
        .MEM_HIT(hit), .MST_NEED(need), .MST_ACTIVE(act), .MST_WRITE(wr),
        .L2_IRQ_PENDING(l2), .EXP_IRQ_PENDING(ex), .DEVSEL(devsel),
        .PERR(perr), .SERR(serr), .INTA(inta), .INTB(intb),
        .REQ_N(req_n), .MST_GO(go), .CFG_SELECT(cfg), .PERR_DESC(desc),
        .M66_MODE(m66_mode));
    pcisb_host_model i_host (.CLK(clk), .RESET(rst), .AD(ad), .CBE_N(cbe),
        .BAD_PAR(bad), .HOLD_GNT(hold), .FLAG_PERR(flag), .REQ_N(req_n),
        .PERR(perr), .PAR(par), .GNT_N(gnt_n), .PERR_LINE_N(perr_n));
    // ***********************************
    // Helpers
    // ***********************************
    task give_verdict;
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'h1)
        begin
            $display("MISMATCH %0t %s", $time, msg);
            n_errors++;
        end
    endtask
    // Cycle counts of pulses and timeout
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        n_serr <= n_serr + int'(serr.oe_n === 1'h0);
        n_perr <= n_perr + int'(perr === 2'b00);
        n_desc <= n_desc + int'(desc === 1'h1);
        n_go <= n_go + int'(go === 1'h1);
        if (serr.oe_n === 1'h0)
            chk(serr.out === 1'h0, "serr drives high");
        if (cyc == 2000)
        begin
            n_errors++;
            give_verdict;
        end
    end
    task phase(input [31:0] a, input [3:0] c, input logic f, i, h, bp);
        @(posedge clk);
        ad <= a;
        cbe <= c;
        fr <= f;
        ir <= i;
        hit <= h;
        bad <= bp;
        #1;
    endtask
    // ***********************************
    // Scenarios
    // ***********************************
    task t_reset;
        @(posedge clk) rst <= 1'h1;
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        #1;
        chk({devsel, perr, serr, inta, intb} === 10'h3d5, "reset pins");
        chk({req_n, go, cfg, desc, m66_mode} === 5'h10, "reset flags");
    endtask
    task t_claim(input [3:0] c, input logic h, s, e, f);
        @(posedge clk) idsel <= s;
        phase(32'h1000_0040, c, 1'h0, 1'h1, h, 1'h0);
        phase(32'h5a5a_a5a5, 4'h0, 1'h1, 1'h0, 1'h0, 1'h0);
        chk(e ? devsel === 2'b00 : devsel.oe_n === 1'h1, "claim");
        chk(cfg === f, "config select");
        phase(~ad, 4'hf, 1'h1, 1'h1, 1'h0, 1'h0);
        chk(devsel.oe_n === !e, "claim hold");
        phase(~ad, 4'hf, 1'h1, 1'h1, 1'h0, 1'h0);
        chk(e ? devsel === 2'b10 : devsel.oe_n === 1'h1, "drive high");
        phase(~ad, 4'hf, 1'h1, 1'h1, 1'h0, 1'h0);
        chk(devsel.oe_n === 1'h1 && cfg === 1'h0, "release");
    endtask
    task t_par(input logic ma, mw, h, ab, db, fl, input int es, ep, ed);
        b0 = n_serr;
        b1 = n_perr;
        b2 = n_desc;
        @(posedge clk);
        act <= ma;
        wr <= mw;
        phase(32'h0000_2000, 4'h7, 1'h0, 1'h1, h, ab);
        phase(32'h3c3c_0f0f, 4'h0, 1'h1, 1'h0, 1'h0, db);
        phase(~ad, 4'hf, 1'h1, 1'h1, 1'h0, 1'h0);
        @(posedge clk) flag <= fl;
        @(posedge clk) flag <= 1'h0;
        act <= 1'h0;
        repeat (6) phase(~ad, 4'hf, 1'h1, 1'h1, 1'h0, 1'h0);
        chk(n_serr - b0 == es, "system error count");
        chk(n_perr - b1 == ep, "parity error count");
        chk(n_desc - b2 == ed, "descriptor count");
    endtask
    task t_irq;
        @(posedge clk) l2 <= 1'h1;
        @(posedge clk) ex <= 1'h1;
        #1 chk(inta === 2'b00 && intb.oe_n === 1'h1, "layer 2 irq");
        @(posedge clk) l2 <= 1'h0;
        #1 chk(intb === 2'b00 && inta === 2'b00, "expansion irq");
        @(posedge clk) ex <= 1'h0;
        #1 chk(inta.oe_n === 1'h1 && intb === 2'b00, "irq level");
        @(posedge clk);
        #1 chk(intb.oe_n === 1'h1, "irq released");
    endtask
    task t_arb;
        b0 = n_go;
        @(posedge clk) need <= 1'h1;
        repeat (6) @(posedge clk);
        #1 chk(req_n === 1'h0, "request");
        chk(n_go == b0, "start without grant");
        @(posedge clk) hold <= 1'h0;
        for (int k = 0; k < 8 && go !== 1'h1; k++)
            @(posedge clk) #1;
        @(posedge clk);
        act <= 1'h1;
        need <= 1'h0;
        #1 chk(n_go - b0 == 1, "one start");
        @(posedge clk) act <= 1'h0;
        repeat (2) @(posedge clk);
        #1 chk(req_n === 1'h1, "request dropped");
    endtask
    task t_m66(input logic v);
        @(posedge clk) m66 <= v;
        @(posedge clk);
        #1 chk(m66_mode === !v, "rate early");
        repeat (2) @(posedge clk);
        #1 chk(m66_mode === v, "rate");
    endtask
    initial
    begin
        t_reset;
        t_claim(4'h7, 1'h1, 1'h0, 1'h1, 1'h0);
        t_claim(4'h7, 1'h0, 1'h0, 1'h0, 1'h0);
        t_claim(CMD_CFG_READ, 1'h0, 1'h1, 1'h1, 1'h1);
        t_claim(CMD_CFG_WRITE, 1'h0, 1'h1, 1'h1, 1'h1);
        t_claim(CMD_CFG_READ, 1'h0, 1'h0, 1'h0, 1'h0);
        t_par(0, 0, 0, 1, 0, 0, 1, 0, 0);
        t_reset;
        t_par(0, 0, 1, 0, 1, 0, 0, 1, 0);
        t_par(1, 0, 0, 0, 1, 0, 0, 1, 1);
        t_par(1, 0, 0, 0, 0, 0, 0, 0, 0);
        t_par(1, 1, 0, 0, 1, 1, 0, 0, 1);
        t_irq;
        t_arb;
        t_m66(1'h1);
        t_m66(1'h0);
        give_verdict;
    end
endmodule
